// ### dv/spf_pin_mux_tb.sv
// self-checking bench for the shared pin function select
`timescale 1ns/1ps
module spf_pin_mux_tb;
    import spf_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [PIN_CNT-1:0] pad_in, pad_out, pad_oe, gpio_out, gpio_dir;
    logic [PIN_CNT-1:0] gpio_in, lvl;
    spf_b5_fn_t sel_b5;
    spf_ser_fn_t sel_b0, sel_b1;
    logic [TEST_CNT-1:0] sel_test_gpio;
    logic t_out, t_oe, t_in, fault, master, sck_out, sck_in, ss_n;
    logic scl_low, sda_low, scl_in, sda_in, tdata, tdi_q, smp;
    logic [PWM_CNT-1:0] mask, pwm_dis;
    spf_tap_state_t tap_state;
    logic [2:0] ext_b;
    logic go, tms_v, tdi_v, p_tck, p_tms, p_tdi, p_busy, p_cap;
    int n_mismatch = 0;
    int n_tests = 0;

    always #5 clk = ~clk;

    // undriven tdo pad shows the inverse of its last value
    assign lvl = {p_tms, p_tck, ~pad_out[4], p_tdi, ext_b};
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & lvl);

    spf_pin_mux DUT (.clk(clk), .rst(rst), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe(pad_oe), .gpio_out(gpio_out),
        .gpio_dir(gpio_dir), .gpio_in(gpio_in), .sel_b5(sel_b5),
        .sel_b0(sel_b0), .sel_b1(sel_b1), .sel_test_gpio(sel_test_gpio),
        .timer_channel_one_out(t_out), .timer_channel_one_oe(t_oe),
        .timer_channel_one_in(t_in), .external_fault_input_three(fault),
        .pwm_fault_mask(mask), .pwm_disable(pwm_dis), .spi_master(master),
        .spi_sck_out(sck_out), .spi_sck_in(sck_in), .spi_ss_n(ss_n),
        .i2c_scl_low(scl_low), .i2c_sda_low(sda_low), .i2c_scl_in(scl_in),
        .i2c_sda_in(sda_in), .tap_data_out(tdata), .tap_state(tap_state),
        .tap_tdi(tdi_q), .tap_sample(smp));

    spf_probe probe (.clk(clk), .rst(rst), .go(go), .tms_v(tms_v),
        .tdi_v(tdi_v), .tdo_pad(pad_in[4]), .tck(p_tck), .tms(p_tms),
        .tdi(p_tdi), .busy(p_busy), .tdo_cap(p_cap));

    task automatic chk(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // outputs stand once the 5-cycle select, pad and input path has passed
    task automatic settle();
        repeat (5) @(posedge clk);
        #1;
    endtask

    task automatic step(input logic m, input logic d);
        int i;
        int pulses;
        pulses = 0;
        @(posedge clk);
        go <= 1'b1;
        tms_v <= m;
        tdi_v <= d;
        @(posedge clk);
        go <= 1'b0;
        // sample pulse count off the edge, one per frame expected
        for (i = 0; i < 40 && (p_busy || i == 0); i++) begin
            @(posedge clk);
            #1;
            pulses += int'(smp);
        end
        settle();
        chk("tap_sample", 16'(pulses), 16'h1);
    endtask

    task automatic t_reset();
        chk("pad_oe", 16'(pad_oe), 16'h0);
        chk("tap_state", 16'(tap_state), 16'(TAP_RESET));
        chk("ss_n", 16'(ss_n), 16'h1);
        chk("scl_in", 16'(scl_in), 16'h1);
        chk("fault", 16'(fault), 16'h0);
    endtask

    task automatic t_gpio();
        @(posedge clk);
        sel_test_gpio <= 4'hf;
        gpio_dir <= 7'h7f;
        gpio_out <= 7'h55;
        settle();
        chk("pad_oe", 16'(pad_oe), 16'h7f);
        chk("pad_out", 16'(pad_out), 16'h55);
        @(posedge clk);
        gpio_dir <= 7'h00;
        ext_b <= 3'h5;
        settle();
        chk("pad_oe", 16'(pad_oe), 16'h0);
        chk("gpio_in", 16'(gpio_in[2:0]), 16'h5);
        @(posedge clk);
        sel_test_gpio <= 4'h0;
        settle();
    endtask

    task automatic t_b5();
        @(posedge clk);
        sel_b5 <= B5_TIMER;
        t_oe <= 1'b1;
        t_out <= 1'b1;
        settle();
        chk("b5_oe", 16'(pad_oe[2]), 16'h1);
        chk("b5_out", 16'(pad_out[2]), 16'h1);
        chk("t_in", 16'(t_in), 16'h1);
        @(posedge clk);
        sel_b5 <= B5_FAULT;
        gpio_dir <= 7'h04;
        mask <= 6'h2a;
        ext_b <= 3'h4;
        settle();
        chk("b5_oe", 16'(pad_oe[2]), 16'h0);
        chk("fault", 16'(fault), 16'h1);
        chk("pwm_dis", 16'(pwm_dis), 16'h2a);
        chk("t_in", 16'(t_in), 16'h0);
        @(posedge clk);
        ext_b <= 3'h0;
        settle();
        chk("pwm_dis", 16'(pwm_dis), 16'h0);
        @(posedge clk);
        sel_b5 <= B5_GPIO;
        settle();
        chk("b5_oe", 16'(pad_oe[2]), 16'h1);
    endtask

    task automatic t_serial();
        @(posedge clk);
        sel_b0 <= SER_SPI;
        sel_b1 <= SER_SPI;
        master <= 1'b1;
        sck_out <= 1'b1;
        gpio_dir <= 7'h03;
        settle();
        chk("b_oe", 16'(pad_oe[1:0]), 16'h1);
        chk("sck_pad", 16'(pad_out[0]), 16'h1);
        chk("ss_n", 16'(ss_n), 16'h0);
        @(posedge clk);
        master <= 1'b0;
        ext_b <= 3'h3;
        settle();
        chk("b0_oe", 16'(pad_oe[0]), 16'h0);
        chk("sck_in", 16'(sck_in), 16'h1);
        chk("ss_n", 16'(ss_n), 16'h1);
        @(posedge clk);
        sel_b0 <= SER_I2C;
        sel_b1 <= SER_I2C;
        scl_low <= 1'b1;
        ext_b <= 3'h2;
        settle();
        chk("b_oe", 16'(pad_oe[1:0]), 16'h1);
        chk("scl_pad", 16'(pad_out[0]), 16'h0);
        chk("scl_in", 16'(scl_in), 16'h0);
        chk("sda_in", 16'(sda_in), 16'h1);
        @(posedge clk);
        sda_low <= 1'b1;
        settle();
        chk("b1_oe", 16'(pad_oe[1]), 16'h1);
        chk("sda_in", 16'(sda_in), 16'h0);
        @(posedge clk);
        sel_b0 <= spf_ser_fn_t'(2'h3);
        sel_b1 <= SER_GPIO;
        settle();
        chk("b_oe", 16'(pad_oe[1:0]), 16'h3);
        @(posedge clk);
        sel_b0 <= SER_GPIO;
        gpio_dir <= 7'h00;
    endtask

    task automatic t_tap();
        step(1'b0, 1'b0);
        chk("tap_state", 16'(tap_state), 16'(TAP_IDLE));
        step(1'b1, 1'b0);
        chk("tap_state", 16'(tap_state), 16'(TAP_SEL_DR));
        step(1'b0, 1'b0);
        chk("tdo_oe", 16'(pad_oe[4]), 16'h0);
        @(posedge clk);
        tdata <= 1'b1;
        step(1'b0, 1'b1);
        chk("tap_state", 16'(tap_state), 16'(TAP_SH_DR));
        chk("tap_tdi", 16'(tdi_q), 16'h1);
        chk("tdo_oe", 16'(pad_oe[4]), 16'h1);
        chk("tdo_pad", 16'(pad_out[4]), 16'h1);
        @(posedge clk);
        tdata <= 1'b0;
        step(1'b0, 1'b0);
        chk("tdo_cap", 16'(p_cap), 16'h1);
        chk("tdo_pad", 16'(pad_out[4]), 16'h0);
        chk("tap_tdi", 16'(tdi_q), 16'h0);
        step(1'b1, 1'b0);
        chk("tap_state", 16'(tap_state), 16'(TAP_EX1_DR));
        chk("tdo_oe", 16'(pad_oe[4]), 16'h0);
    endtask

    initial begin
        gpio_out = 7'h00;
        gpio_dir = 7'h00;
        sel_b5 = B5_GPIO;
        sel_b0 = SER_GPIO;
        sel_b1 = SER_GPIO;
        sel_test_gpio = 4'h0;
        {t_out, t_oe, master, sck_out, scl_low, sda_low, tdata} = 7'h00;
        mask = 6'h00;
        ext_b = 3'h7;
        {go, tms_v, tdi_v} = 3'h0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        settle();
        t_reset();
        t_gpio();
        t_b5();
        t_serial();
        t_tap();
        summarize();
    end

    // whole run needs well under 1000 cycles
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        summarize();
    end
endmodule // spf_pin_mux_tb

// ### dv/spf_probe.sv
// test probe model: frames of tck with tms and tdi, captures tdo
`timescale 1ns/1ps
module spf_probe (
    input  logic clk,
    input  logic rst,
    input  logic go,
    input  logic tms_v,
    input  logic tdi_v,
    input  logic tdo_pad,
    output logic tck,
    output logic tms,
    output logic tdi,
    output logic busy,
    output logic tdo_cap
);
    logic [3:0] cnt;

    assign busy = (cnt != 4'h0);

    // tck stands low between frames; tms and tdi held well past the rise
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt     <= 4'h0;
            tck     <= 1'b0;
            tms     <= 1'b1;
            tdi     <= 1'b1;
            tdo_cap <= 1'b0;
        end else if (go) begin
            cnt <= 4'h1;
            tms <= tms_v;
            tdi <= tdi_v;
        end else if (busy) begin
            cnt <= (cnt == 4'hc) ? 4'h0 : cnt + 4'h1;
            if (cnt == 4'h2) begin
                tck     <= 1'b1;
                tdo_cap <= tdo_pad;
            end
            if (cnt == 4'h7) begin
                tck <= 1'b0;
            end
            // hold ended: lines no longer show the sent value
            if (cnt == 4'hc) begin
                tms <= ~tms;
                tdi <= ~tdi;
            end
        end
    end
endmodule // spf_probe

// ### hdl/spf_pin_mux.sv
// shared pin function select for port b lines and test port pins
`timescale 1ns/1ps
// What this block does
// - gpio pins individually input or output
// - port_b_line5 resets to gpio, alternates selected
// - fault three input only, disables chosen pwm
// - test clock default, alternate port_d_line2
// - test mode select default, alternate port_d_line3
// - mode select sampled on rising test clock
// - test data in default, rising edge, port_d_line0
// - test data out driven only in shift states
// - test data out changes on falling clock
// - test data out default, alternate port_d_line1
// - port_b_line0 gpio default, spi or i2c clock
// - spi clock output master, input slave
// - port_b_line1 gpio default, slave select, i2c data
module spf_pin_mux
    import spf_pkg::*;
#(
    parameter logic FAULT_ACTIVE = 1'b1
) (
    input  logic                clk,
    input  logic                rst,
    input  logic [PIN_CNT-1:0]  pad_in,
    output logic [PIN_CNT-1:0]  pad_out,
    output logic [PIN_CNT-1:0]  pad_oe,
    input  logic [PIN_CNT-1:0]  gpio_out,
    input  logic [PIN_CNT-1:0]  gpio_dir,
    output logic [PIN_CNT-1:0]  gpio_in,
    input  spf_b5_fn_t          sel_b5,
    input  spf_ser_fn_t         sel_b0,
    input  spf_ser_fn_t         sel_b1,
    input  logic [TEST_CNT-1:0] sel_test_gpio,
    input  logic                timer_channel_one_out,
    input  logic                timer_channel_one_oe,
    output logic                timer_channel_one_in,
    output logic                external_fault_input_three,
    input  logic [PWM_CNT-1:0]  pwm_fault_mask,
    output logic [PWM_CNT-1:0]  pwm_disable,
    input  logic                spi_master,
    input  logic                spi_sck_out,
    output logic                spi_sck_in,
    output logic                spi_ss_n,
    input  logic                i2c_scl_low,
    input  logic                i2c_sda_low,
    output logic                i2c_scl_in,
    output logic                i2c_sda_in,
    input  logic                tap_data_out,
    output spf_tap_state_t      tap_state,
    output logic                tap_tdi,
    output logic                tap_sample
);

    logic [PIN_CNT-1:0]  pin_s;
    spf_b5_fn_t          fn_b5;
    spf_ser_fn_t         fn_b0;
    spf_ser_fn_t         fn_b1;
    logic [TEST_CNT-1:0] test_gpio;
    logic                tck_prev;
    logic                tck_active;
    logic                tck_rise;
    logic                tck_fall;
    logic                tms_bit;
    logic                tdi_bit;
    logic                shift_active;
    logic                tdo_bit;
    logic                tdo_drive;
    logic                fault_now;
    logic [PIN_CNT-1:0]  next_pad_out;
    logic [PIN_CNT-1:0]  next_pad_oe;

    spf_sync #(
        .WIDTH (PIN_CNT)
    ) u_sync (
        .clk      (clk),
        .rst      (rst),
        .async_in (pad_in),
        .sync_out (pin_s)
    );

    // function selects held locally so reset gives the default functions
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fn_b5     <= B5_RST_FN;
            fn_b0     <= SER_RST_FN;
            fn_b1     <= SER_RST_FN;
            test_gpio <= TEST_GPIO_RST;
        end else begin
            fn_b5     <= sel_b5;
            fn_b0     <= sel_b0;
            fn_b1     <= sel_b1;
            test_gpio <= sel_test_gpio;
        end
    end

    // test clock arrives as a pin, so its edges become enables here
    assign tck_active = !test_gpio[TSEL_TCK];
    assign tck_rise   = tck_active && pin_s[PIN_TCK] && !tck_prev;
    assign tck_fall   = tck_active && !pin_s[PIN_TCK] && tck_prev;
    // a mode select pin lent to gpio reads as the pull-up level
    assign tms_bit = test_gpio[TSEL_TMS] ? TMS_IDLE_LVL : pin_s[PIN_TMS];
    assign tdi_bit = test_gpio[TSEL_TDI] ? 1'b1 : pin_s[PIN_TDI];
    assign shift_active = (tap_state == TAP_SH_DR) ||
                          (tap_state == TAP_SH_IR);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            // same as the synchroniser's reset output: no false edge
            tck_prev <= 1'b0;
        end else begin
            tck_prev <= pin_s[PIN_TCK];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tap_state <= TAP_RESET;
        end else if (tck_rise) begin
            tap_state <= spf_tap_next(tap_state, tms_bit);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tap_tdi    <= 1'b0;
            tap_sample <= 1'b0;
        end else begin
            tap_sample <= tck_rise;
            if (tck_rise) begin
                tap_tdi <= tdi_bit;
            end
        end
    end

    spf_tdo_stage u_tdo (
        .clk          (clk),
        .rst          (rst),
        .fall_en      (tck_fall),
        .shift_active (shift_active),
        .data_in      (tap_data_out),
        .tdo_bit      (tdo_bit),
        .tdo_drive    (tdo_drive)
    );

    // pad drivers: gpio first, then each selected peripheral takes over
    always_comb begin
        next_pad_out = gpio_out;
        next_pad_oe  = gpio_dir;
        unique case (fn_b5)
            B5_TIMER: begin
                next_pad_out[PIN_B5] = timer_channel_one_out;
                next_pad_oe[PIN_B5]  = timer_channel_one_oe;
            end
            B5_FAULT: begin
                next_pad_out[PIN_B5] = 1'b0;
                next_pad_oe[PIN_B5]  = 1'b0;
            end
            default: ;
        endcase
        unique case (fn_b0)
            SER_SPI: begin
                next_pad_out[PIN_B0] = spi_sck_out;
                next_pad_oe[PIN_B0]  = spi_master;
            end
            SER_I2C: begin
                // open drain: only ever pulls low
                next_pad_out[PIN_B0] = 1'b0;
                next_pad_oe[PIN_B0]  = i2c_scl_low;
            end
            default: ;
        endcase
        unique case (fn_b1)
            SER_SPI: begin
                next_pad_out[PIN_B1] = 1'b0;
                next_pad_oe[PIN_B1]  = 1'b0;
            end
            SER_I2C: begin
                next_pad_out[PIN_B1] = 1'b0;
                next_pad_oe[PIN_B1]  = i2c_sda_low;
            end
            default: ;
        endcase
        if (!test_gpio[TSEL_TDI]) begin
            next_pad_out[PIN_TDI] = 1'b0;
            next_pad_oe[PIN_TDI]  = 1'b0;
        end
        if (!test_gpio[TSEL_TCK]) begin
            next_pad_out[PIN_TCK] = 1'b0;
            next_pad_oe[PIN_TCK]  = 1'b0;
        end
        if (!test_gpio[TSEL_TMS]) begin
            next_pad_out[PIN_TMS] = 1'b0;
            next_pad_oe[PIN_TMS]  = 1'b0;
        end
        if (!test_gpio[TSEL_TDO]) begin
            next_pad_out[PIN_TDO] = tdo_bit;
            next_pad_oe[PIN_TDO]  = tdo_drive;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pad_out <= PAD_RST;
            pad_oe  <= PAD_RST;
        end else begin
            pad_out <= next_pad_out;
            pad_oe  <= next_pad_oe;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gpio_in <= PAD_RST;
        end else begin
            gpio_in <= pin_s;
        end
    end

    // deselected peripheral inputs rest at their idle levels
    assign fault_now = (fn_b5 == B5_FAULT) && (pin_s[PIN_B5] == FAULT_ACTIVE);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            external_fault_input_three <= 1'b0;
            pwm_disable                <= PWM_RST;
        end else begin
            external_fault_input_three <= fault_now;
            pwm_disable <= fault_now ? pwm_fault_mask : PWM_RST;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            timer_channel_one_in <= 1'b0;
            spi_sck_in           <= 1'b0;
            spi_ss_n             <= 1'b1;
            i2c_scl_in           <= 1'b1;
            i2c_sda_in           <= 1'b1;
        end else begin
            timer_channel_one_in <= (fn_b5 == B5_TIMER) && pin_s[PIN_B5];
            // slave clock only; a master reads nothing back
            spi_sck_in <= (fn_b0 == SER_SPI) && !spi_master &&
                          pin_s[PIN_B0];
            spi_ss_n   <= (fn_b1 == SER_SPI) ? pin_s[PIN_B1] : 1'b1;
            i2c_scl_in <= (fn_b0 == SER_I2C) ? pin_s[PIN_B0] : 1'b1;
            i2c_sda_in <= (fn_b1 == SER_I2C) ? pin_s[PIN_B1] : 1'b1;
        end
    end

    sequence s_tck_rise;
        tck_rise;
    endsequence
    sequence s_released;
        $past(rst) && !rst;
    endsequence

    property p_gpio_dir;
        @(posedge clk) disable iff (rst)
        fn_b5 == B5_GPIO |=> pad_oe[PIN_B5] == $past(gpio_dir[PIN_B5]);
    endproperty
    a_gpio_dir: assert property (p_gpio_dir)
        else $error("gpio direction not followed on port_b_line5");

    property p_defaults;
        @(posedge clk)
        s_released |-> fn_b5 == B5_GPIO && fn_b0 == SER_GPIO &&
                       fn_b1 == SER_GPIO && test_gpio == TEST_GPIO_RST;
    endproperty
    a_defaults: assert property (p_defaults)
        else $error("pin functions not at defaults after reset");

    property p_fault_in;
        @(posedge clk) disable iff (rst)
        fn_b5 == B5_FAULT |=> !pad_oe[PIN_B5];
    endproperty
    a_fault_in: assert property (p_fault_in)
        else $error("fault pin driven");
    property p_fault_pwm;
        @(posedge clk) disable iff (rst)
        ##1 pwm_disable == (($past(fn_b5) == B5_FAULT &&
                             $past(pin_s[PIN_B5]) == FAULT_ACTIVE) ?
                            $past(pwm_fault_mask) : PWM_RST);
    endproperty
    a_fault_pwm: assert property (p_fault_pwm)
        else $error("pwm disable does not follow fault");
    property p_test_in;
        @(posedge clk) disable iff (rst)
        !test_gpio[TSEL_TCK] && !test_gpio[TSEL_TMS] |=>
            !pad_oe[PIN_TCK] && !pad_oe[PIN_TMS];
    endproperty
    a_test_in: assert property (p_test_in)
        else $error("test input pin driven");

    property p_tms_step;
        @(posedge clk) disable iff (rst)
        s_tck_rise |=> tap_state == spf_tap_next($past(tap_state),
                                                 $past(tms_bit));
    endproperty
    a_tms_step: assert property (p_tms_step)
        else $error("controller did not step on rising test clock");

    property p_tap_hold;
        @(posedge clk) disable iff (rst)
        !tck_rise |=> $stable(tap_state);
    endproperty
    a_tap_hold: assert property (p_tap_hold)
        else $error("controller moved without rising test clock");
    property p_tdi;
        @(posedge clk) disable iff (rst)
        s_tck_rise |=> tap_sample && tap_tdi == $past(tdi_bit);
    endproperty
    a_tdi: assert property (p_tdi)
        else $error("test data in not sampled");

    property p_sck_dir;
        @(posedge clk) disable iff (rst)
        fn_b0 == SER_SPI |=> pad_oe[PIN_B0] == $past(spi_master);
    endproperty
    a_sck_dir: assert property (p_sck_dir)
        else $error("spi clock direction wrong");
    property p_ss_in;
        @(posedge clk) disable iff (rst)
        fn_b1 == SER_SPI |=> !pad_oe[PIN_B1];
    endproperty
    a_ss_in: assert property (p_ss_in)
        else $error("slave select pin driven");
    property p_override;
        @(posedge clk) disable iff (rst)
        fn_b0 == SER_I2C |=> !pad_out[PIN_B0] &&
                             pad_oe[PIN_B0] == $past(i2c_scl_low);
    endproperty
    a_override: assert property (p_override)
        else $error("gpio setting leaked into i2c clock pin");

endmodule // spf_pin_mux

// ### hdl/spf_pkg.sv
// shared pin function select: pin indices, function codes, reset values
package spf_pkg;

    localparam int PIN_CNT = 7;
    localparam int PWM_CNT = 6;
    localparam int TEST_CNT = 4;

    // pad vector positions
    localparam int PIN_B0  = 0;
    localparam int PIN_B1  = 1;
    localparam int PIN_B5  = 2;
    localparam int PIN_TDI = 3;
    localparam int PIN_TDO = 4;
    localparam int PIN_TCK = 5;
    localparam int PIN_TMS = 6;

    // test pin select bits, bit n set means port_d_line n
    localparam int TSEL_TDI = 0;
    localparam int TSEL_TDO = 1;
    localparam int TSEL_TCK = 2;
    localparam int TSEL_TMS = 3;

    typedef enum logic [1:0] {
        B5_GPIO  = 2'h0,
        B5_TIMER = 2'h1,
        B5_FAULT = 2'h2
    } spf_b5_fn_t;

    typedef enum logic [1:0] {
        SER_GPIO = 2'h0,
        SER_SPI  = 2'h1,
        SER_I2C  = 2'h2
    } spf_ser_fn_t;

    localparam spf_b5_fn_t  B5_RST_FN  = B5_GPIO;
    localparam spf_ser_fn_t SER_RST_FN = SER_GPIO;
    localparam logic [TEST_CNT-1:0] TEST_GPIO_RST = 4'h0;
    localparam logic [PIN_CNT-1:0]  PAD_RST       = 7'h00;
    localparam logic [PWM_CNT-1:0]  PWM_RST       = 6'h00;
    localparam logic                TMS_IDLE_LVL  = 1'b1;

    typedef enum logic [15:0] {
        TAP_RESET  = 16'h0001,
        TAP_IDLE   = 16'h0002,
        TAP_SEL_DR = 16'h0004,
        TAP_CAP_DR = 16'h0008,
        TAP_SH_DR  = 16'h0010,
        TAP_EX1_DR = 16'h0020,
        TAP_PAU_DR = 16'h0040,
        TAP_EX2_DR = 16'h0080,
        TAP_UPD_DR = 16'h0100,
        TAP_SEL_IR = 16'h0200,
        TAP_CAP_IR = 16'h0400,
        TAP_SH_IR  = 16'h0800,
        TAP_EX1_IR = 16'h1000,
        TAP_PAU_IR = 16'h2000,
        TAP_EX2_IR = 16'h4000,
        TAP_UPD_IR = 16'h8000
    } spf_tap_state_t;

    // controller next state, shared by the logic and its checks
    function automatic spf_tap_state_t spf_tap_next(spf_tap_state_t s,
                                                    logic tms);
        spf_tap_state_t n;
        n = TAP_RESET;
        unique case (s)
            TAP_RESET:  n = tms ? TAP_RESET  : TAP_IDLE;
            TAP_IDLE:   n = tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: n = tms ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: n = tms ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR:  n = tms ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: n = tms ? TAP_UPD_DR : TAP_PAU_DR;
            TAP_PAU_DR: n = tms ? TAP_EX2_DR : TAP_PAU_DR;
            TAP_EX2_DR: n = tms ? TAP_UPD_DR : TAP_SH_DR;
            TAP_UPD_DR: n = tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: n = tms ? TAP_RESET  : TAP_CAP_IR;
            TAP_CAP_IR: n = tms ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR:  n = tms ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: n = tms ? TAP_UPD_IR : TAP_PAU_IR;
            TAP_PAU_IR: n = tms ? TAP_EX2_IR : TAP_PAU_IR;
            TAP_EX2_IR: n = tms ? TAP_UPD_IR : TAP_SH_IR;
            TAP_UPD_IR: n = tms ? TAP_SEL_DR : TAP_IDLE;
            default:    n = TAP_RESET;
        endcase
        return n;
    endfunction

endpackage

// ### hdl/spf_sync.sv
// two flip-flop synchroniser for pad inputs
`timescale 1ns/1ps
module spf_sync #(
    parameter int WIDTH = 7
) (
    input  logic             clk,
    input  logic             rst,
    input  logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;

    // meta is read by sync_out only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta     <= '0;
            sync_out <= '0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule // spf_sync

// ### hdl/spf_tdo_stage.sv
// test data output stage, moves only on the falling test clock
`timescale 1ns/1ps
module spf_tdo_stage (
    input  logic clk,
    input  logic rst,
    input  logic fall_en,
    input  logic shift_active,
    input  logic data_in,
    output logic tdo_bit,
    output logic tdo_drive
);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tdo_bit   <= 1'b0;
            tdo_drive <= 1'b0;
        end else if (fall_en) begin
            tdo_bit   <= data_in;
            tdo_drive <= shift_active;
        end
    end

    property p_tdo_window;
        @(posedge clk) disable iff (rst)
        fall_en |=> tdo_drive == $past(shift_active);
    endproperty
    a_tdo_window: assert property (p_tdo_window)
        else $error("tdo driven outside a shift state");

    property p_tdo_hold;
        @(posedge clk) disable iff (rst)
        !fall_en |=> $stable(tdo_bit) && $stable(tdo_drive);
    endproperty
    a_tdo_hold: assert property (p_tdo_hold)
        else $error("tdo changed away from a falling test clock");
endmodule // spf_tdo_stage
